//--- hdl/ittw_pkg.sv
// ittw_pkg: register map, field positions, codes and walker states
// assumes one 100 MHz clock domain shared by bus, walker and memory port

package ittw_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [11:0] R_CTRL = 12'h000; // translator_enable
	localparam logic [11:0] R_STAT = 12'h004; // idle, busy, memory collections
	localparam logic [11:0] R_TYPE = 12'h008; // collection features, read only
	localparam logic [11:0] R_CCAP = 12'h00c; // memory collection capacity
	localparam logic [11:0] R_BASE = 12'h100; // table_base_reg n: lo at +8n, hi at +8n+4
	localparam logic [11:0] R_BASE_MASK = 12'hf00; // region decode for the base registers

	// ----------------------------------------------------------------
	// table_base_reg field positions (64-bit view)
	// ----------------------------------------------------------------
	localparam int BF_VALID = 63; // table valid
	localparam int BF_IND = 62; // two-level select
	localparam int BF_TYPE = 56; // 3-bit table type, read only
	localparam int BF_AHI = 51; // address top bit
	localparam int BF_ADDR = 12; // address bottom bit
	localparam int BF_ESZ = 10; // 2-bit log2(entry bytes) - 3
	localparam int BF_PSZ = 8; // 2-bit page size code
	localparam int BF_SZ = 0; // 8-bit page count minus one

	// ----------------------------------------------------------------
	// level-1 entry, control bits and reset values
	// ----------------------------------------------------------------
	localparam int L1_VALID = 63; // level-1 entry valid
	localparam int L1_ENT_LOG2 = 3; // 64-bit level-1 entries
	localparam int CID_DEF_W = 16; // identifier width when the limit flag is clear
	localparam int CTRL_EN = 0; // enable bit in R_CTRL
	localparam logic CTRL_RST = 1'b0; // translator_enable after reset
	localparam logic [63:0] BASE_RST = 64'h0; // table_base_reg after reset

	// table type codes and walk result codes
	localparam logic [2:0] TT_NONE = 3'h0;
	localparam logic [2:0] TT_DEV = 3'h1;
	localparam logic [2:0] TT_VPE = 3'h2;
	localparam logic [2:0] TT_COLL = 3'h4;
	localparam logic [1:0] RS_OK = 2'h0; // resp_addr holds the entry address
	localparam logic [1:0] RS_INT = 2'h1; // collection held inside the device
	localparam logic [1:0] RS_DISC = 2'h2; // write discarded
	localparam logic [1:0] RS_ERR = 2'h3; // no access possible

	typedef enum logic [1:0] {S_IDLE, S_CHK, S_LOOK, S_WAIT} ittw_st_t;

	// page size code to log2 of bytes; the spare code reads as the largest page
	function automatic logic [4:0] ittw_pg_log2(input logic [1:0] c);
		return (c == 2'h0) ? 5'h0c : (c == 2'h1) ? 5'h0e : 5'h10;
	endfunction : ittw_pg_log2

endpackage : ittw_pkg

//--- hdl/ittw_l1c.sv
// ittw_l1c: storage of the level-1 entry cache, one write and one read port
// assumes the caller keeps per-line valid bits; read data come one cycle late
`timescale 1ns/1ps
`default_nettype none

module ittw_l1c #(
	parameter int W = 76, // tag plus level-2 address
	parameter int D = 8, // lines
	parameter int AW = 3 // line index width
)(
	input wire logic clk, // walker clock
	input wire logic we, // write strobe
	input wire logic [AW-1:0] waddr, // write line
	input wire logic [W-1:0] wdata, // write word
	input wire logic [AW-1:0] raddr, // read line
	output logic [W-1:0] rdata // registered read word
);
	logic [W-1:0] mem [D];

	// ----------------------------------------------------------------
	// array and output register
	// ----------------------------------------------------------------
	// no reset on data: the owner's valid bits say what is meaningful
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end

endmodule : ittw_l1c
`default_nettype wire

//--- hdl/ittw_walk.sv
// ittw_walk: table base registers, translator control and table walker
// assumes an AHB-Lite master on hclk, requests and memory data from hclk logic
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - two-level select in each base register chooses flat or two-level walk.
// - level-1 entries are read as 64-bit words.
// - level-1 bit 63 says whether its address points to a level-2 table.
// - level-2 base sits in bits 51 to N; bits 62-52 and below N reserved.
// - level-1 index is identifier divided by entries per page.
// - invalid level-1 entry, non-collection table: writes are discarded silently.
// - invalid level-1 entry, collection at or above internal count: writes discarded.
// - disabled and idle: no table memory access at all.
// - enabled or busy: never touch a table whose base is invalid in the S_CHK cycle.
// - invalid level-1 entries are never cached.
// - memory collections exist only if some base register has collection type.
// - collection capacity is computed from pages, page size and entry size.
// - collections below the internal count live inside, higher ones in memory.
// - internal count zero means every collection lives in memory.
// - identifier width is 16, or the width field plus one when the limit flag is set.
// - device table is indexed by device id; entry layout is kept by software.
// - every table access goes to the non-secure address space.
module ittw_walk import ittw_pkg::*; #(
	parameter int NT = 4, // number of table base registers, at least two
	parameter logic [3*NT-1:0] TYPES = {TT_NONE, TT_VPE, TT_COLL, TT_DEV}, // type per base
	parameter logic [7:0] HCC = 8'h04, // internal_collection_count
	parameter logic CIL = 1'b0, // collection_id_limit_flag
	parameter logic [3:0] CIDW = 4'hf, // collection_id_width minus one
	parameter int CD = 8 // level-1 cache lines, a power of two
)(
	input wire logic hclk, // bus and walker clock
	input wire logic hresetn, // asynchronous reset, active low
	input wire logic hsel, // slave select
	input wire logic [11:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write not read
	input wire logic [2:0] hsize, // only word transfers are expected
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // never inserts wait states
	output logic hresp, // always OKAY
	output logic [31:0] hrdata, // read data
	input wire logic req_valid, // walk request
	output logic req_ready, // walker can take a request
	input wire logic [$clog2(NT)-1:0] req_table, // which base register
	input wire logic [31:0] req_id, // device, collection or vPE identifier
	input wire logic req_write, // walk on behalf of a table write
	output logic resp_valid, // one-cycle result pulse
	output logic [1:0] resp_status, // RS_* code
	output logic [51:0] resp_addr, // entry address when RS_OK
	output logic mem_req, // one-cycle level-1 read pulse
	output logic [51:0] mem_addr, // level-1 entry address
	output logic mem_nonsecure, // address space of table accesses
	input wire logic mem_rvalid, // read data valid
	input wire logic [63:0] mem_rdata, // level-1 entry
	output logic translator_idle_flag // disabled and no walk in progress
);
	localparam int TW = $clog2(NT);
	localparam int CIW = $clog2(CD);
	localparam int CWW = TW + 32 + (BF_AHI - BF_ADDR + 1);

	typedef struct packed {
		logic en; // translator_enable
		logic [NT-1:0][63:0] base; // table_base_reg, type bits overlaid on read
		logic dwr; // write data phase pending
		logic [11:0] da; // data phase address
		logic [31:0] rdata; // bus read data
		logic hrdy; // bus ready
		logic hrsp; // bus response
		ittw_st_t st; // walk state
		logic [TW-1:0] tbl; // table of the walk
		logic [31:0] id; // identifier of the walk
		logic wr; // walk is for a write
		logic rv; // result pulse
		logic [1:0] rst; // result code
		logic [51:0] addr; // result address
		logic mreq; // memory read pulse
		logic [51:0] maddr; // memory address
		logic ns; // non-secure marker
		logic rdy; // request ready
		logic idle; // quiescent flag
		logic [CD-1:0] cv; // cache line valid bits
	} ittw_s_t;

	localparam ittw_s_t S_RST = '{
		en: CTRL_RST, base: {NT{BASE_RST}}, dwr: 1'b0, da: 12'h000, rdata: 32'h0,
		hrdy: 1'b1, hrsp: 1'b0, st: S_IDLE, tbl: '0, id: 32'h0, wr: 1'b0,
		rv: 1'b0, rst: RS_OK, addr: 52'h0, mreq: 1'b0, maddr: 52'h0,
		ns: 1'b1, rdy: 1'b0, idle: 1'b1, cv: '0
	};

	ittw_s_t s;
	ittw_s_t n;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic is_base(input logic [11:0] a);
		return ((a & R_BASE_MASK) == R_BASE) && (32'(a[7:3]) < NT);
	endfunction : is_base

	// type field always shows the built-in type, whatever software wrote
	function automatic logic [63:0] bview(input logic [63:0] r, input logic [2:0] t);
		logic [63:0] v;
		v = r;
		v[BF_TYPE +: 3] = t;
		return v;
	endfunction : bview

	function automatic logic [31:0] ccap_f(input logic [63:0] b);
		logic [4:0] pl;
		logic [4:0] el;
		logic [39:0] c;
		pl = ittw_pg_log2(b[BF_PSZ +: 2]);
		el = 5'(L1_ENT_LOG2) + 5'(b[BF_ESZ +: 2]);
		c = 40'(b[BF_SZ +: 8]) + 40'h1;
		if (b[BF_IND]) begin
			c = c << (pl - 5'(L1_ENT_LOG2) + pl - el);
		end else begin
			c = c << (pl - el);
		end
		// saturate: a huge two-level table cannot be shown in one word
		return (c[39:32] != 8'h00) ? 32'hffff_ffff : c[31:0];
	endfunction : ccap_f

	// ----------------------------------------------------------------
	// walk arithmetic for the table of the walk in progress
	// ----------------------------------------------------------------
	logic [63:0] tb;
	logic [2:0] ty;
	logic [4:0] pl;
	logic [4:0] el;
	logic [4:0] pe;
	logic [4:0] cw;
	logic [31:0] l1i;
	logic [31:0] sz1;
	logic [31:0] flim;
	logic [31:0] llim;
	logic [51:0] tabase;
	logic [51:0] off;
	logic [11:0] off_lo;
	logic [51:0] l1a;
	logic [39:0] l2mask;
	logic [39:0] l2f;
	logic cid_bad;
	logic below_hcc;
	logic [CIW-1:0] ci;
	logic [TW+31:0] tag;
	logic [CWW-1:0] c_rd;
	logic c_hit;

	assign tb = s.base[s.tbl];
	assign ty = TYPES[3*s.tbl +: 3];
	assign pl = ittw_pg_log2(tb[BF_PSZ +: 2]);
	assign el = 5'(L1_ENT_LOG2) + 5'(tb[BF_ESZ +: 2]);
	assign pe = pl - el;
	assign tabase = 52'(tb[BF_AHI:BF_ADDR]) << BF_ADDR;
	assign sz1 = 32'(tb[BF_SZ +: 8]) + 32'h1;
	assign flim = sz1 << pe;
	// level-1 pages hold page size / 8 pointers
	assign llim = sz1 << (pl - 5'(L1_ENT_LOG2));
	assign l1i = s.id >> pe;
	assign off = 52'(s.id & ((32'h1 << pe) - 32'h1)) << el;
	assign off_lo = off[11:0];
	assign l1a = tabase + (52'(l1i) << L1_ENT_LOG2);
	// bits below the page size are reserved in the entry and dropped here
	assign l2mask = ~((40'h1 << (pl - 5'(BF_ADDR))) - 40'h1);
	assign l2f = mem_rdata[BF_AHI:BF_ADDR] & l2mask;
	assign cw = CIL ? 5'(CIDW) + 5'h1 : 5'(CID_DEF_W);
	assign cid_bad = (ty == TT_COLL) && ((s.id >> cw) != 32'h0);
	assign below_hcc = s.id < 32'(HCC);
	assign ci = l1i[CIW-1:0];
	assign tag = {s.tbl, l1i};
	assign c_hit = s.cv[ci] && (c_rd[CWW-1 -: TW+32] == tag);

	// ----------------------------------------------------------------
	// level-1 cache storage
	// ----------------------------------------------------------------
	logic cwe;

	ittw_l1c #(.W(CWW), .D(CD), .AW(CIW)) u_l1c (
		.clk(hclk),
		.we(cwe),
		.waddr(ci),
		.wdata({tag, l2f}),
		.raddr(ci),
		.rdata(c_rd)
	);

	// ----------------------------------------------------------------
	// next state: walker, bus writes, bus reads
	// ----------------------------------------------------------------
	logic ap;
	logic cmem;
	logic [31:0] ccap;
	logic [63:0] bw;

	always_comb begin
		n = s;
		cwe = 1'b0;
		cmem = 1'b0;
		ccap = 32'h0;
		bw = 64'h0;
		ap = hsel && htrans[1] && hready;
		n.rv = 1'b0;
		n.mreq = 1'b0;
		n.ns = 1'b1;
		n.hrdy = 1'b1;
		n.hrsp = 1'b0;
		// walker: a request is only ever taken while enabled
		unique case (s.st)
			S_IDLE: begin
				if (req_valid && s.rdy) begin
					n.tbl = req_table;
					n.id = req_id;
					n.wr = req_write;
					n.st = S_CHK;
				end
			end
			S_CHK: begin
				n.st = S_IDLE;
				n.rv = 1'b1;
				n.rst = RS_ERR;
				n.addr = 52'h0;
				if (!tb[BF_VALID] || (ty == TT_NONE) || cid_bad) begin
					n.rst = RS_ERR;
				end else if ((ty == TT_COLL) && below_hcc) begin
					n.rst = RS_INT;
				end else if (!tb[BF_IND]) begin
					if (s.id < flim) begin
						n.rst = RS_OK;
						n.addr = tabase + off;
					end
				end else if (l1i < llim) begin
					n.rv = 1'b0;
					n.st = S_LOOK;
				end
			end
			S_LOOK: begin
				if (c_hit) begin
					n.st = S_IDLE;
					n.rv = 1'b1;
					n.rst = RS_OK;
					n.addr = (52'(c_rd[BF_AHI-BF_ADDR:0]) << BF_ADDR) + off;
				end else begin
					n.mreq = 1'b1;
					n.maddr = l1a;
					n.st = S_WAIT;
				end
			end
			S_WAIT: begin
				if (mem_rvalid) begin
					n.st = S_IDLE;
					n.rv = 1'b1;
					if (mem_rdata[L1_VALID]) begin
						cwe = 1'b1;
						n.cv[ci] = 1'b1;
						n.rst = RS_OK;
						n.addr = (52'(l2f) << BF_ADDR) + off;
					end else if (s.wr && (ty != TT_COLL)) begin
						n.rst = RS_DISC;
					end else if (s.wr && !below_hcc) begin
						n.rst = RS_DISC;
					end else begin
						n.rst = RS_ERR;
					end
				end
			end
		endcase
		// bus write data phase; any base change or disable empties the cache
		if (s.dwr) begin
			if (s.da == R_CTRL) begin
				n.en = hwdata[CTRL_EN];
			end else if (is_base(s.da)) begin
				if (s.da[2]) begin
					n.base[s.da[3 +: TW]][63:32] = hwdata;
				end else begin
					n.base[s.da[3 +: TW]][31:0] = hwdata;
				end
				n.cv = '0;
			end
		end
		if (!n.en) begin
			n.cv = '0;
		end
		n.rdy = (n.st == S_IDLE) && n.en;
		n.idle = !n.en && (n.st == S_IDLE);
		// lowest collection-type base sets the memory capacity
		for (int i = NT - 1; i >= 0; i--) begin
			if (TYPES[3*i +: 3] == TT_COLL) begin
				cmem = 1'b1;
				ccap = ccap_f(n.base[i]);
			end
		end
		// address phase: capture, and read from the already-updated copy
		n.dwr = ap && hwrite;
		n.da = haddr;
		n.rdata = 32'h0;
		if (ap && !hwrite) begin
			if (haddr == R_CTRL) begin
				n.rdata = 32'(n.en);
			end else if (haddr == R_STAT) begin
				n.rdata = {29'h0, cmem, n.st != S_IDLE, n.idle};
			end else if (haddr == R_TYPE) begin
				n.rdata = {18'h0, cmem, CIDW, CIL, HCC};
			end else if (haddr == R_CCAP) begin
				n.rdata = ccap;
			end else if (is_base(haddr)) begin
				bw = bview(n.base[haddr[3 +: TW]], TYPES[3*haddr[3 +: TW] +: 3]);
				n.rdata = haddr[2] ? bw[63:32] : bw[31:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s <= S_RST;
		end else begin
			s <= n;
		end
	end

	assign hreadyout = s.hrdy;
	assign hresp = s.hrsp;
	assign hrdata = s.rdata;
	assign req_ready = s.rdy;
	assign resp_valid = s.rv;
	assign resp_status = s.rst;
	assign resp_addr = s.addr;
	assign mem_req = s.mreq;
	assign mem_addr = s.maddr;
	assign mem_nonsecure = s.ns;
	assign translator_idle_flag = s.idle;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	logic req_bvalid;
	logic req_flat;
	assign req_bvalid = s.base[req_table][BF_VALID];
	assign req_flat = !s.base[req_table][BF_IND] && (TYPES[3*req_table +: 3] == TT_DEV);

	sequence q_take;
		req_valid && req_ready;
	endsequence

	sequence q_l1_valid;
		(s.st == S_WAIT) && mem_rvalid && mem_rdata[L1_VALID];
	endsequence

	a_idle_no_access: assert property (@(posedge hclk) disable iff (!hresetn)
		translator_idle_flag |-> !mem_req ##1 !mem_req)
		else $error("table access while idle");

	a_bad_base_err: assert property (@(posedge hclk) disable iff (!hresetn)
		(q_take ##0 !req_bvalid) |=> !mem_req ##1 (resp_valid && resp_status == RS_ERR))
		else $error("invalid base not refused");

	a_flat_direct: assert property (@(posedge hclk) disable iff (!hresetn)
		(q_take ##0 (req_bvalid && req_flat)) |=> !mem_req ##1 resp_valid)
		else $error("flat walk not answered in two cycles");

	a_l1_word_fetch: assert property (@(posedge hclk) disable iff (!hresetn)
		mem_req |-> (mem_addr[2:0] == 3'h0) && (s.st == S_WAIT) && mem_nonsecure)
		else $error("level-1 fetch misaligned or not non-secure");

	a_l1_resolve: assert property (@(posedge hclk) disable iff (!hresetn)
		q_l1_valid |=> resp_valid && (resp_status == RS_OK) && (resp_addr[11:0] == $past(off_lo)))
		else $error("level-2 address kept reserved bits");

	a_no_inval_cache: assert property (@(posedge hclk) disable iff (!hresetn)
		((s.st == S_WAIT) && mem_rvalid && !mem_rdata[L1_VALID]) |=> ((s.cv & ~$past(s.cv)) == '0))
		else $error("invalid level-1 entry cached");

	a_discard_write: assert property (@(posedge hclk) disable iff (!hresetn)
		(resp_valid && resp_status == RS_DISC) |-> s.wr && (ty != TT_COLL || !below_hcc))
		else $error("discard without a write");

	a_hcc_internal: assert property (@(posedge hclk) disable iff (!hresetn)
		(resp_valid && resp_status == RS_INT) |-> (ty == TT_COLL) && below_hcc && $past(s.st == S_CHK))
		else $error("internal collection mis-routed");

	a_cid_width: assert property (@(posedge hclk) disable iff (!hresetn)
		($past(s.st == S_CHK) && resp_valid && cid_bad) |-> (resp_status == RS_ERR))
		else $error("oversized collection id accepted");

	a_hcc_zero_mem: assert property (@(posedge hclk) disable iff (!hresetn)
		(HCC == 8'h00) |-> cmem)
		else $error("no memory collections with zero internal count");

endmodule : ittw_walk
`default_nettype wire

//--- dv/ittw_mem.sv
// ittw_mem: memory holding level-1 entries, answers each walker read once
// assumes one read in flight at a time, same clock as the walker
`timescale 1ns/1ps
`default_nettype none

module ittw_mem (
	input wire logic hclk, // walker clock
	input wire logic hresetn, // asynchronous reset, active low
	input wire logic mem_req, // read request pulse
	input wire logic [51:0] mem_addr, // entry address
	output logic mem_rvalid, // read data pulse
	output logic [63:0] mem_rdata // entry read back
);
	// ----------------------------------------------------------------
	// storage and delayed answer
	// ----------------------------------------------------------------
	logic [63:0] mem [longint]; // words never written read as zero
	int wait_n;
	logic pend;
	logic [51:0] addr_r;

	// random delay of 0 to 5 cycles; between answers the data lines keep toggling
	// so a walker that samples them outside the pulse picks up garbage
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend <= 1'b0;
			mem_rvalid <= 1'b0;
			mem_rdata <= '1;
		end else begin
			mem_rvalid <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_req) begin
				pend <= 1'b1;
				addr_r <= mem_addr;
				wait_n <= $urandom % 6;
			end else if (pend && wait_n > 0) begin
				wait_n <= wait_n - 1;
			end else if (pend) begin
				pend <= 1'b0;
				mem_rvalid <= 1'b1;
				mem_rdata <= mem.exists(addr_r) ? mem[addr_r] : 64'h0;
			end
		end
	end
endmodule : ittw_mem

`default_nettype wire

//--- dv/tb.sv
// tb: self-checking bench for the table walker against an integer model
// assumes ittw_mem stands behind the level-1 read port, one clock domain
`timescale 1ns/1ps
`default_nettype none
`define chk(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("Error at %0t: got %0h expected %0h", $time, (g), (e)); end end

module tb import ittw_pkg::*;;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam logic [7:0] HCC = 8'h04; // internal_collection_count
	logic hclk = 1'b0, hresetn = 1'b1, hsel = 1'b1, hwrite = 1'b0;
	logic [11:0] haddr = 12'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0, hrdata, r;
	logic hreadyout, hresp, req_ready, resp_valid, mem_req, mem_nonsecure, mem_rvalid;
	logic req_valid = 1'b0, req_write = 1'b0, translator_idle_flag;
	logic [1:0] req_table = 2'h0, resp_status;
	logic [31:0] req_id = 32'h0;
	logic [51:0] resp_addr, mem_addr;
	logic [63:0] mem_rdata;
	logic [63:0] bases [4] = '{default: 64'h0};
	logic [2:0] ty [4] = '{TT_DEV, TT_COLL, TT_VPE, TT_NONE};
	longint exp_l1a = 0;
	int mismatches = 0, samples_checked = 0, mem_cnt = 0, c0, i;

	ittw_walk #(.HCC(HCC)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
		.req_ready(req_ready), .req_table(req_table), .req_id(req_id), .req_write(req_write),
		.resp_valid(resp_valid), .resp_status(resp_status), .resp_addr(resp_addr),
		.mem_req(mem_req), .mem_addr(mem_addr), .mem_nonsecure(mem_nonsecure),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
		.translator_idle_flag(translator_idle_flag));
	ittw_mem u_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_addr(mem_addr),
		.mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));

	always #5 hclk = ~hclk; // 100 MHz

	// ----------------------------------------------------------------
	// reference model of one walk
	// ----------------------------------------------------------------
	function automatic void model(input int t, input longint id, input bit wr,
		output logic [1:0] st, output longint a, output longint l1a);
		logic [63:0] b, e;
		longint ba, esz, pl, per, idx, pg;
		b = bases[t];
		ba = {b[51:12], 12'h0};
		esz = b[11:10] + 3;
		pl = (b[9:8] == 2'h0) ? 12 : (b[9:8] == 2'h1) ? 14 : 16;
		pg = b[7:0] + 1;
		per = pl - esz;
		idx = id >> per;
		l1a = ba + idx * 8;
		a = 0;
		st = RS_ERR;
		if (!b[63] || ty[t] == TT_NONE) return;
		if (ty[t] == TT_COLL && id >= 65536) return;
		if (ty[t] == TT_COLL && id < HCC) begin
			st = RS_INT;
		end else if (!b[62]) begin
			if (id < ((pg << pl) >> esz)) begin
				st = RS_OK;
				a = ba + (id << esz);
			end
		end else if (idx < ((pg << pl) >> 3)) begin
			e = u_mem.mem.exists(l1a) ? u_mem.mem[l1a] : 64'h0;
			if (e[63]) begin
				st = RS_OK;
				a = ((e[51:0] >> pl) << pl) + ((id & ((64'h1 << per) - 1)) << esz);
			end else if (wr) begin
				st = RS_DISC;
			end
		end
	endfunction : model

	// ----------------------------------------------------------------
	// bus, walk and closing tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude

	// a wait that runs out is a failure in itself
	task automatic limit(input int n);
		if (n >= 100) begin
			mismatches++;
			conclude();
		end
	endtask : limit

	task automatic bus(input logic [11:0] ad, input bit wr, input logic [31:0] wd);
		int n;
		haddr <= ad;
		hwrite <= wr;
		htrans <= 2'b10;
		n = 0;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		htrans <= 2'b00;
		hwdata <= wd;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 100);
		r = hrdata;
		limit(n);
	endtask : bus

	task automatic rdchk(input logic [11:0] ad, input logic [31:0] ex);
		bus(ad, 1'b0, 32'h0);
		`chk(r, ex)
	endtask : rdchk

	// type bits are built in, so the model keeps only what software owns
	task automatic wbase(input int n, input logic [63:0] v);
		bus(R_BASE + 12'(8 * n), 1'b1, v[31:0]);
		bus(R_BASE + 12'(8 * n + 4), 1'b1, v[63:32]);
		bases[n] = v;
	endtask : wbase

	task automatic walk(input int t, input longint id, input bit wr);
		logic [1:0] st;
		longint a;
		int n;
		model(t, id, wr, st, a, exp_l1a);
		req_table <= 2'(t);
		req_id <= id[31:0];
		req_write <= wr;
		req_valid <= 1'b1;
		n = 0;
		do begin @(posedge hclk); n++; end while (req_ready !== 1'b1 && n < 100);
		req_valid <= 1'b0;
		limit(n);
		n = 0;
		do begin @(posedge hclk); n++; end while (resp_valid !== 1'b1 && n < 100);
		limit(n);
		`chk(resp_status, st)
		`chk(resp_addr, a[51:0])
	endtask : walk

	// ----------------------------------------------------------------
	// port monitor
	// ----------------------------------------------------------------
	always @(posedge hclk) begin
		`chk(mem_nonsecure, 1'b1)
		if (hresetn && mem_req) begin
			mem_cnt++;
			`chk(translator_idle_flag, 1'b0)
			`chk(mem_addr, exp_l1a[51:0])
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(64));
		// a real falling edge, so the asynchronous reset branches fire at time zero
		hresetn <= 1'b0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`chk(translator_idle_flag, 1'b1)
		rdchk(R_TYPE, 32'h0000_3e04);
		rdchk(R_STAT, 32'h0000_0005);
		rdchk(12'h800, 32'h0);
		wbase(0, 64'h8000_0000_0001_0000);
		wbase(1, 64'hc000_0000_0002_0000);
		wbase(2, 64'h8000_0000_0003_0400);
		rdchk(R_BASE + 12'h00c, 32'hc400_0000);
		rdchk(R_CCAP, 32'h0004_0000);
		bus(R_CTRL, 1'b1, 32'h1);
		// a new valid entry is in place before any walk needs it
		u_mem.mem[64'h20000] = 64'hfff0_0000_0050_0fff;
		c0 = mem_cnt;
		walk(1, 10, 1'b0);
		walk(1, 10, 1'b0);
		`chk(mem_cnt, c0 + 1)
		walk(1, 600, 1'b1);
		walk(1, 600, 1'b1);
		`chk(mem_cnt, c0 + 3)
		walk(1, 2, 1'b1);
		walk(1, 70000, 1'b0);
		`chk(mem_cnt, c0 + 3)
		for (i = 0; i < 40; i++) begin
			walk($urandom % 4, $urandom % 1100, 1'($urandom));
		end
		wbase(0, 64'hc000_0000_0001_0000);
		u_mem.mem[64'h10008] = 64'h8000_0000_0060_0000;
		walk(0, 600, 1'b0);
		walk(0, 1100, 1'b1);
		walk(0, 1100, 1'b0);
		wbase(1, 64'h4000_0000_0002_0000);
		c0 = mem_cnt;
		walk(1, 10, 1'b0);
		`chk(mem_cnt, c0)
		bus(R_CTRL, 1'b1, 32'h0);
		repeat (2) @(posedge hclk);
		`chk(translator_idle_flag, 1'b1)
		`chk(req_ready, 1'b0)
		rdchk(R_STAT, 32'h0000_0005);
		conclude();
	end
endmodule : tb

`default_nettype wire
